// file: logic/ufm_pkg.sv
// package: constants and carriers for the usb port fault monitor
`default_nettype none
package ufm_pkg;
   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned OC_DEGLITCH_MS   = 8;
   localparam int unsigned OV_DEGLITCH_MS   = 16;
   localparam int unsigned LD_SET_MS        = 210;
   localparam int unsigned LD_RESET_MS      = 3000;
   localparam int unsigned DCHG_LONG_MS     = 2000;
   localparam int unsigned DCHG_SHORT_MS    = 320;
   localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
   localparam int unsigned OC_DEGLITCH_CYC  = OC_DEGLITCH_MS * CYC_PER_MS;
   localparam int unsigned OV_DEGLITCH_CYC  = OV_DEGLITCH_MS * CYC_PER_MS;
   localparam int unsigned LD_SET_CYC       = LD_SET_MS * CYC_PER_MS;
   localparam int unsigned LD_RESET_CYC     = LD_RESET_MS * CYC_PER_MS;
   localparam int unsigned DCHG_LONG_CYC    = DCHG_LONG_MS * CYC_PER_MS;
   localparam int unsigned DCHG_SHORT_CYC   = DCHG_SHORT_MS * CYC_PER_MS;
   localparam int unsigned CNT_W            = 32;

   // port modes as seen by this block
   typedef enum logic [2:0] {
      UFM_MODE_DATA      = 3'b000,
      UFM_MODE_CHARGE_DP = 3'b001,
      UFM_MODE_AUTO_CHG  = 3'b010,
      UFM_MODE_CLIENT    = 3'b011,
      UFM_MODE_RP_DATA   = 3'b100,
      UFM_MODE_RP_DED    = 3'b101
   } ufm_mode_t;

   // raw comparator inputs
   typedef struct packed {
      logic over_current;
      logic dplus_line_ov;
      logic dminus_line_ov;
      logic thermal_trip_limited;
      logic thermal_trip_normal;
      logic load_above_set;
      logic load_below_reset;
   } ufm_sense_t;

   // switch and discharge controls
   typedef struct packed {
      logic power_switch_en;
      logic data_switch_en;
      logic out_discharge_en;
      logic data_discharge_en;
      logic high_current_limit_sel;
   } ufm_drive_t;
endpackage : ufm_pkg
`default_nettype wire

// file: logic/ufm_filter.sv
// one-sided or two-sided persistence filter built from a restartable counter
`default_nettype none
module ufm_filter
   import ufm_pkg::*;
#(
   parameter int unsigned SET_CYC = 1,
   parameter int unsigned CLR_CYC = 1
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic raw_i,
   output logic      filt_o
);
   logic [CNT_W-1:0] count;

   // counter runs only while raw disagrees with output; restarts when it agrees
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count  <= '0;
         filt_o <= 1'b0;
      end else if (raw_i == filt_o) begin
         count <= '0;
      end else if ((raw_i && count >= CNT_W'(SET_CYC - 1)) ||
                   (!raw_i && count >= CNT_W'(CLR_CYC - 1))) begin
         count  <= '0;
         filt_o <= raw_i;
      end else begin
         count <= count + CNT_W'(1);
      end
   end
endmodule : ufm_filter
`default_nettype wire

// file: logic/ufm_monitor.sv
// top: fault filtering, switch control, discharge sequencing, load detect
//
// Functional notes
// - single active-low fault output from all sources
// - overcurrent fault deglitched 8 ms both ways
// - no overcurrent fault in reduced-power modes
// - data line overvoltage opens data switches immediately
// - data overvoltage fault after 16 ms, instant release
// - thermal trip kills power and data switches
// - thermal fault asserts with no deglitch
// - switches return after 20 degree cooldown, cycling
// - renegotiation: power off, discharge, power on
// - data discharge path on during overvoltage
// - overvoltage clear restores data switches automatically
// - load detect sets after 210 ms above
// - load detect clears after 3 s below
// - high limit charging, low limit non-charging
// - mode change into or out of auto charging: discharge hold 2 s or 320 ms
`default_nettype none
module ufm_monitor
   import ufm_pkg::*;
#(
   parameter int unsigned OC_CYC   = OC_DEGLITCH_CYC,
   parameter int unsigned OV_CYC   = OV_DEGLITCH_CYC,
   parameter int unsigned LDS_CYC  = LD_SET_CYC,
   parameter int unsigned LDR_CYC  = LD_RESET_CYC,
   parameter int unsigned DL_CYC   = DCHG_LONG_CYC,
   parameter int unsigned DS_CYC   = DCHG_SHORT_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire ufm_sense_t sense_i,
   input  wire ufm_mode_t  mode_i,
   input  wire logic       renegotiate_i,
   input  wire logic       thermal_cool_i,
   output ufm_drive_t      drive_o,
   output logic            fault_n_o,
   output logic            fault_oe_o,
   output logic            load_detect_o
);
   function automatic logic is_charging(input ufm_mode_t m);
      return (m == UFM_MODE_CHARGE_DP) || (m == UFM_MODE_AUTO_CHG);
   endfunction : is_charging

   function automatic logic is_reduced(input ufm_mode_t m);
      return (m == UFM_MODE_RP_DATA) || (m == UFM_MODE_RP_DED);
   endfunction : is_reduced

   // saturating run-length step shared by the persistence checks
   function automatic logic [CNT_W-1:0] run_step(input logic             cond,
                                                 input logic [CNT_W-1:0] run);
      if (!cond) begin
         return '0;
      end
      return (run == '1) ? run : run + CNT_W'(1);
   endfunction : run_step

   typedef enum logic [1:0] {
      UFM_DS_IDLE = 2'b00,
      UFM_DS_HOLD = 2'b01
   } ufm_dchg_t;

   logic             oc_filt;
   logic             ov_filt;
   logic             ld_set_filt;
   logic             ld_clr_filt;
   logic             ov_raw;
   logic             thermal_raw;
   logic             thermal_off;
   ufm_mode_t        prev_mode;
   ufm_dchg_t        dstate;
   logic [CNT_W-1:0] dcount;
   logic [CNT_W-1:0] dlimit;
   logic             oc_fault;
   logic             next_fault;
   logic [CNT_W-1:0] oc_hi_run;
   logic [CNT_W-1:0] oc_lo_run;
   logic [CNT_W-1:0] ov_hi_run;
   logic [CNT_W-1:0] ld_hi_run;
   logic [CNT_W-1:0] ld_lo_run;

   assign ov_raw = sense_i.dplus_line_ov | sense_i.dminus_line_ov;
   // trip threshold follows whether current limit is active
   assign thermal_raw = sense_i.over_current ? sense_i.thermal_trip_limited
                                             : sense_i.thermal_trip_normal;

   ufm_filter #(.SET_CYC(OC_CYC), .CLR_CYC(OC_CYC)) u_oc (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .raw_i   (sense_i.over_current),
      .filt_o  (oc_filt)
   );

   ufm_filter #(.SET_CYC(OV_CYC), .CLR_CYC(1)) u_ov (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .raw_i   (ov_raw),
      .filt_o  (ov_filt)
   );

   ufm_filter #(.SET_CYC(LDS_CYC), .CLR_CYC(1)) u_ld_set (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .raw_i   (sense_i.load_above_set),
      .filt_o  (ld_set_filt)
   );

   ufm_filter #(.SET_CYC(LDR_CYC), .CLR_CYC(1)) u_ld_clr (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .raw_i   (sense_i.load_below_reset),
      .filt_o  (ld_clr_filt)
   );

   // the fast filter needs one cycle to release; gate with raw so release is immediate
   assign oc_fault   = oc_filt & ~is_reduced(mode_i);
   assign next_fault = oc_fault | (ov_filt & ov_raw) | thermal_raw | thermal_off;

   // thermal shutdown latched until the cool-down comparator reports 20 degrees below trip
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         thermal_off <= 1'b0;
      end else if (thermal_raw) begin
         thermal_off <= 1'b1;
      end else if (thermal_cool_i) begin
         thermal_off <= 1'b0;
      end
   end

   // mode-change and renegotiation discharge sequencing
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         // track the pin in reset so release never shows a false mode edge
         prev_mode <= mode_i;
         dstate    <= UFM_DS_IDLE;
         dcount    <= '0;
         dlimit    <= '0;
      end else begin
         prev_mode <= mode_i;
         case (dstate)
            UFM_DS_IDLE: begin
               dcount <= '0;
               if (mode_i != prev_mode && mode_i == UFM_MODE_AUTO_CHG) begin
                  dlimit <= CNT_W'(DL_CYC);
                  dstate <= UFM_DS_HOLD;
               end else if (mode_i != prev_mode && prev_mode == UFM_MODE_AUTO_CHG) begin
                  dlimit <= CNT_W'(DS_CYC);
                  dstate <= UFM_DS_HOLD;
               end else if (renegotiate_i) begin
                  dlimit <= CNT_W'(DS_CYC);
                  dstate <= UFM_DS_HOLD;
               end
            end
            UFM_DS_HOLD: begin
               if (dcount >= dlimit - CNT_W'(1)) begin
                  dstate <= UFM_DS_IDLE;
               end else begin
                  dcount <= dcount + CNT_W'(1);
               end
            end
            default: dstate <= UFM_DS_IDLE;
         endcase
      end
   end

   // outputs: all registered
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         drive_o    <= '0;
         fault_n_o  <= 1'b1;
         fault_oe_o <= 1'b0;
      end else begin
         drive_o.power_switch_en  <= ~(thermal_raw | thermal_off) &
                                     (dstate == UFM_DS_IDLE) &
                                     (mode_i != UFM_MODE_CLIENT);
         drive_o.out_discharge_en <= (dstate == UFM_DS_HOLD);
         drive_o.data_switch_en   <= ~ov_raw & ~(thermal_raw | thermal_off);
         drive_o.data_discharge_en <= ov_raw;
         drive_o.high_current_limit_sel <= is_charging(mode_i);
         fault_n_o  <= 1'b0;
         fault_oe_o <= next_fault;
      end
   end

   // load-detect status, charging modes only
   always_ff @(posedge clk_i) begin
      if (reset_i || !is_charging(mode_i)) begin
         load_detect_o <= 1'b0;
      end else if (ld_set_filt) begin
         load_detect_o <= 1'b1;
      end else if (ld_clr_filt) begin
         load_detect_o <= 1'b0;
      end
   end

   // run lengths of the raw inputs, only for the checks below; they saturate, never wrap
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         oc_hi_run <= '0;
         oc_lo_run <= '0;
         ov_hi_run <= '0;
         ld_hi_run <= '0;
         ld_lo_run <= '0;
      end else begin
         oc_hi_run <= run_step(sense_i.over_current, oc_hi_run);
         oc_lo_run <= run_step(!sense_i.over_current, oc_lo_run);
         ov_hi_run <= run_step(ov_raw, ov_hi_run);
         ld_hi_run <= run_step(sense_i.load_above_set, ld_hi_run);
         ld_lo_run <= run_step(sense_i.load_below_reset, ld_lo_run);
      end
   end

   a_data_sw_open: assert property (@(posedge clk_i) disable iff (reset_i)
      ov_raw |=> !drive_o.data_switch_en)
      else $error("data switch not opened on overvoltage");
   a_ov_disch_on: assert property (@(posedge clk_i) disable iff (reset_i)
      ov_raw |=> drive_o.data_discharge_en)
      else $error("data discharge off during overvoltage");
   a_ov_release: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(ov_raw) && !sense_i.over_current && !thermal_raw && !thermal_off
      && !oc_filt |=> !fault_oe_o)
      else $error("overvoltage fault not released at once");
   a_thermal_fault: assert property (@(posedge clk_i) disable iff (reset_i)
      thermal_raw |=> fault_oe_o && !drive_o.power_switch_en)
      else $error("thermal trip not reported immediately");
   a_thermal_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      thermal_off && !thermal_cool_i |=> thermal_off)
      else $error("thermal shutdown released before cooldown");
   a_rp_no_oc: assert property (@(posedge clk_i) disable iff (reset_i)
      is_reduced(mode_i) && !ov_raw && !thermal_raw && !thermal_off |=> !fault_oe_o)
      else $error("overcurrent fault in reduced power mode");
   a_oc_short: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(sense_i.over_current) && !oc_filt |=> !oc_filt)
      else $error("overcurrent passed without deglitch");
   a_ilim_sel: assert property (@(posedge clk_i) disable iff (reset_i)
      is_charging(mode_i) |=> drive_o.high_current_limit_sel)
      else $error("wrong current limit selected");
   a_disch_pwr: assert property (@(posedge clk_i) disable iff (reset_i)
      drive_o.out_discharge_en |-> !drive_o.power_switch_en)
      else $error("power on during output discharge");
   a_ld_idle: assert property (@(posedge clk_i) disable iff (reset_i)
      !is_charging(mode_i) |=> !load_detect_o)
      else $error("load detect set outside charging mode");

   // filter timing against the raw run lengths
   a_oc_set_time: assert property (@(posedge clk_i) disable iff (reset_i)
      oc_hi_run >= CNT_W'(OC_CYC) |-> oc_filt)
      else $error("overcurrent held past deglitch but not filtered");
   a_oc_clr_time: assert property (@(posedge clk_i) disable iff (reset_i)
      oc_lo_run >= CNT_W'(OC_CYC) |-> !oc_filt)
      else $error("overcurrent gone past deglitch but still filtered");
   a_oc_rise_late: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(oc_filt) |-> oc_hi_run >= CNT_W'(OC_CYC))
      else $error("overcurrent filter set early");
   a_oc_fall_late: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(oc_filt) |-> oc_lo_run >= CNT_W'(OC_CYC))
      else $error("overcurrent filter cleared early");
   a_ov_set_time: assert property (@(posedge clk_i) disable iff (reset_i)
      ov_hi_run >= CNT_W'(OV_CYC) |-> ov_filt)
      else $error("overvoltage held past deglitch but not filtered");
   a_ov_rise_late: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(ov_filt) |-> ov_hi_run >= CNT_W'(OV_CYC))
      else $error("overvoltage filter set early");
   a_ld_set_time: assert property (@(posedge clk_i) disable iff (reset_i)
      ld_hi_run >= CNT_W'(LDS_CYC) |-> ld_set_filt)
      else $error("heavy load held but set filter idle");
   a_ld_rise_late: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(ld_set_filt) |-> ld_hi_run >= CNT_W'(LDS_CYC))
      else $error("load set filter fired early");
   a_ld_clr_time: assert property (@(posedge clk_i) disable iff (reset_i)
      ld_lo_run >= CNT_W'(LDR_CYC) |-> ld_clr_filt)
      else $error("light load held but clear filter idle");
   a_ld_clr_late: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(ld_clr_filt) |-> ld_lo_run >= CNT_W'(LDR_CYC))
      else $error("load clear filter fired early");

   // fault pin and status outputs
   a_ov_fault_on: assert property (@(posedge clk_i) disable iff (reset_i)
      ov_filt && ov_raw |=> fault_oe_o)
      else $error("filtered overvoltage not reported");
   a_oc_fault_on: assert property (@(posedge clk_i) disable iff (reset_i)
      oc_filt && !is_reduced(mode_i) |=> fault_oe_o)
      else $error("filtered overcurrent not reported");
   a_fault_cause: assert property (@(posedge clk_i) disable iff (reset_i)
      !oc_filt && !ov_raw && !thermal_raw && !thermal_off |=> !fault_oe_o)
      else $error("fault reported with no source");
   a_fault_pin_drive: assert property (@(posedge clk_i) disable iff (reset_i)
      fault_oe_o |-> !fault_n_o)
      else $error("fault pin driven high");
   a_ld_set_out: assert property (@(posedge clk_i) disable iff (reset_i)
      is_charging(mode_i) && ld_set_filt |=> load_detect_o)
      else $error("load detect not set");
   a_ld_clr_out: assert property (@(posedge clk_i) disable iff (reset_i)
      is_charging(mode_i) && ld_clr_filt && !ld_set_filt |=> !load_detect_o)
      else $error("load detect not cleared");
   a_ilim_low: assert property (@(posedge clk_i) disable iff (reset_i)
      !is_charging(mode_i) |=> !drive_o.high_current_limit_sel)
      else $error("high limit outside charging mode");

   // switch control
   a_data_sw_close: assert property (@(posedge clk_i) disable iff (reset_i)
      !ov_raw && !thermal_raw && !thermal_off |=> drive_o.data_switch_en
      && !drive_o.data_discharge_en)
      else $error("data path not restored after overvoltage");
   a_thermal_data: assert property (@(posedge clk_i) disable iff (reset_i)
      thermal_raw |=> !drive_o.data_switch_en)
      else $error("data switch left closed on thermal trip");
   a_thermal_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      thermal_off && thermal_cool_i && !thermal_raw |=> !thermal_off)
      else $error("thermal shutdown kept after cooldown");
   a_power_back: assert property (@(posedge clk_i) disable iff (reset_i)
      !thermal_raw && !thermal_off && dstate == UFM_DS_IDLE
      && mode_i != UFM_MODE_CLIENT |=> drive_o.power_switch_en)
      else $error("power switch not restored");

   // discharge sequencing
   a_disch_long: assert property (@(posedge clk_i) disable iff (reset_i)
      dstate == UFM_DS_IDLE && $changed(mode_i) && mode_i == UFM_MODE_AUTO_CHG
      |=> dstate == UFM_DS_HOLD && dlimit == CNT_W'(DL_CYC))
      else $error("long discharge hold not started");
   a_disch_short: assert property (@(posedge clk_i) disable iff (reset_i)
      dstate == UFM_DS_IDLE && $changed(mode_i) && $past(mode_i) == UFM_MODE_AUTO_CHG
      |=> dstate == UFM_DS_HOLD && dlimit == CNT_W'(DS_CYC))
      else $error("short discharge hold not started");
   a_reneg_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      dstate == UFM_DS_IDLE && renegotiate_i |=> dstate == UFM_DS_HOLD)
      else $error("renegotiation discharge not started");
   a_hold_bound: assert property (@(posedge clk_i) disable iff (reset_i)
      dstate == UFM_DS_HOLD |-> dcount < dlimit)
      else $error("discharge hold overran its limit");
endmodule : ufm_monitor
`default_nettype wire

// file: verification/ufm_manager_model.sv
// partner model: system power manager sharing power between this port and one peer
`default_nettype none
module ufm_manager_model
   import ufm_pkg::*;
(
   input  wire logic      load_detect_i,
   input  wire logic      peer_loaded_i,
   input  wire ufm_mode_t base_mode_i,
   output ufm_mode_t      mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // one heavy port allowed: demote this port from UFM_MODE_CHARGE_DP while the peer holds the budget
   // the base mode returns as soon as the peer drops its load flag
   always_comb begin
      mode_o = base_mode_i;
      if (peer_loaded_i && !load_detect_i && base_mode_i == UFM_MODE_CHARGE_DP) begin
         mode_o = UFM_MODE_RP_DATA;
      end
   end
endmodule : ufm_manager_model
`default_nettype wire

// file: verification/ufm_monitor_bench.sv
// testbench: fault filtering, thermal cycling, discharge holds and load detect
`default_nettype none
`define CHK(g, e) chk_v(32'(g), 32'(e))
module ufm_monitor_bench
   import ufm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned OC = 8, OV = 16, LDS = 20, LDR = 30, DL = 40, DS = 12;
   logic       clk_i, reset_i, renegotiate_i, thermal_cool_i, peer, fault_n_o;
   logic       fault_oe_o, load_detect_o;
   ufm_sense_t sense_i;
   ufm_mode_t  base_mode, mode_i;
   ufm_drive_t drive_o;
   int         errors, tests_run;
   int         cycles = 0;

   ufm_monitor #(.OC_CYC(OC), .OV_CYC(OV), .LDS_CYC(LDS), .LDR_CYC(LDR), .DL_CYC(DL),
      .DS_CYC(DS)) dut (.clk_i(clk_i), .reset_i(reset_i), .sense_i(sense_i),
      .mode_i(mode_i), .renegotiate_i(renegotiate_i), .thermal_cool_i(thermal_cool_i),
      .drive_o(drive_o), .fault_n_o(fault_n_o), .fault_oe_o(fault_oe_o),
      .load_detect_o(load_detect_o));
   ufm_manager_model mgr (.load_detect_i(load_detect_o), .peer_loaded_i(peer),
      .base_mode_i(base_mode), .mode_o(mode_i));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // a hang is cut short well beyond the longest sequence
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors = errors + 1;
         complete_run();
      end
   end

   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_v
   // inputs move 1 ns after the edge, outputs are read at the same point
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_n
   task automatic complete_run();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      errors = 0; tests_run = 0;
      reset_i = 1'b1; sense_i = '0; base_mode = UFM_MODE_CHARGE_DP; peer = 1'b0;
      renegotiate_i = 1'b0; thermal_cool_i = 1'b0;
      wait_n(20);
      reset_i = 1'b0;
      wait_n(3);
      `CHK(drive_o.power_switch_en, 1'b1);
      `CHK(drive_o.high_current_limit_sel, 1'b1);
      `CHK({fault_n_o, fault_oe_o}, 2'b00);
      // overcurrent glitch shorter than the deglitch, then a steady episode
      sense_i.over_current = 1'b1; wait_n(OC - 2);
      sense_i.over_current = 1'b0; wait_n(OC + 3);
      `CHK(fault_oe_o, 1'b0);
      sense_i.over_current = 1'b1; wait_n(OC - 1);
      `CHK(fault_oe_o, 1'b0);
      wait_n(4);
      `CHK(fault_oe_o, 1'b1);
      // overvoltage on top, still within its deglitch, does not keep the pin low after overcurrent goes
      sense_i.dminus_line_ov = 1'b1; wait_n(2);
      `CHK({drive_o.data_switch_en, drive_o.data_discharge_en}, 2'b01);
      sense_i.over_current = 1'b0; wait_n(OC + 4);
      `CHK(fault_oe_o, 1'b0);
      sense_i.dminus_line_ov = 1'b0; wait_n(3);
      `CHK({drive_o.data_switch_en, drive_o.data_discharge_en}, 2'b10);
      sense_i.dplus_line_ov = 1'b1; wait_n(OV - 1);
      `CHK(fault_oe_o, 1'b0);
      wait_n(4);
      `CHK(fault_oe_o, 1'b1);
      sense_i.over_current = 1'b1; wait_n(OC + 4);
      sense_i.dplus_line_ov = 1'b0; wait_n(2);
      `CHK(fault_oe_o, 1'b1);
      sense_i.over_current = 1'b0; wait_n(OC + 4);
      `CHK(fault_oe_o, 1'b0);
      // reduced-power dedicated mode never reports overcurrent
      base_mode = UFM_MODE_RP_DED; sense_i.over_current = 1'b1; wait_n(OC + 4);
      `CHK(fault_oe_o, 1'b0);
      `CHK(drive_o.high_current_limit_sel, 1'b0);
      sense_i.over_current = 1'b0; base_mode = UFM_MODE_CHARGE_DP; wait_n(OC + 4);
      // overvoltage alone: reported after its deglitch, released at once
      sense_i.dplus_line_ov = 1'b1; wait_n(OV + 2);
      `CHK(fault_oe_o, 1'b1);
      sense_i.dplus_line_ov = 1'b0; wait_n(2);
      `CHK({fault_oe_o, drive_o.data_switch_en}, 2'b01);
      // thermal trips act at once and release only after cooling
      sense_i.thermal_trip_normal = 1'b1; wait_n(2);
      `CHK({drive_o.power_switch_en, drive_o.data_switch_en, fault_oe_o}, 3'b001);
      sense_i.thermal_trip_normal = 1'b0; wait_n(4);
      `CHK(drive_o.power_switch_en, 1'b0);
      thermal_cool_i = 1'b1; wait_n(3);
      `CHK({drive_o.power_switch_en, drive_o.data_switch_en, fault_oe_o}, 3'b110);
      thermal_cool_i = 1'b0;
      sense_i.over_current = 1'b1; sense_i.thermal_trip_limited = 1'b1; wait_n(2);
      `CHK({drive_o.power_switch_en, fault_oe_o}, 2'b01);
      sense_i = '0; thermal_cool_i = 1'b1; wait_n(OC + 4);
      `CHK({drive_o.power_switch_en, fault_oe_o}, 2'b10);
      thermal_cool_i = 1'b0;
      // load detect with the manager demoting this port while the peer is loaded
      sense_i.load_above_set = 1'b1; wait_n(LDS - 1);
      `CHK(load_detect_o, 1'b0);
      wait_n(5);
      `CHK(load_detect_o, 1'b1);
      sense_i.load_above_set = 1'b0; sense_i.load_below_reset = 1'b1; wait_n(LDR - 1);
      `CHK(load_detect_o, 1'b1);
      wait_n(5);
      `CHK(load_detect_o, 1'b0);
      peer = 1'b1; wait_n(2);
      `CHK(drive_o.high_current_limit_sel, 1'b0);
      peer = 1'b0; wait_n(2);
      `CHK(drive_o.high_current_limit_sel, 1'b1);
      sense_i = '0;
      // mode change holds: long towards auto charging, short back
      base_mode = UFM_MODE_AUTO_CHG; wait_n(3);
      `CHK({drive_o.power_switch_en, drive_o.out_discharge_en}, 2'b01);
      wait_n(DL - 4);
      `CHK(drive_o.out_discharge_en, 1'b1);
      wait_n(8);
      `CHK({drive_o.power_switch_en, drive_o.out_discharge_en}, 2'b10);
      base_mode = UFM_MODE_CHARGE_DP; wait_n(3);
      `CHK(drive_o.out_discharge_en, 1'b1);
      wait_n(DS + 4);
      `CHK({drive_o.power_switch_en, drive_o.out_discharge_en}, 2'b10);
      // renegotiation pulse in idle
      renegotiate_i = 1'b1; wait_n(1);
      renegotiate_i = 1'b0; wait_n(2);
      `CHK({drive_o.power_switch_en, drive_o.out_discharge_en}, 2'b01);
      wait_n(DS + 4);
      `CHK({drive_o.power_switch_en, drive_o.out_discharge_en}, 2'b10);
      // client mode: non-charging limit, power switch held off
      base_mode = UFM_MODE_CLIENT; wait_n(2);
      `CHK({drive_o.power_switch_en, drive_o.high_current_limit_sel}, 2'b00);
      complete_run();
   end
endmodule : ufm_monitor_bench
`default_nettype wire
